// ===== hdl/pfm_converter_top.sv
// The Wishbone interface to the registers and the address map are this design's own decisions.
`default_nettype none
// Function
// - Nonzero on-cap field ends converter A charge at the cap time.
// - Cap time is 70 ns times (1 + 4 x field).
// - Capped on-time ends charging before peak current is reached.
// - Without off-cap, discharge ends only on zero-current detect.
// - Nonzero off-cap ends discharge after set time regardless.
// - Switched rail follows its control bit.
// - In mode 3, threshold field sets switching to regulator handover.
// - Mode 3 uses A spacing when switching, C spacing as regulator.
// - Pulses count to rail A when switching, rail C as regulator.
// - Regulator C standalone output is off while paralleled.
// - Converter B is buck only, codes 1 and 3.
// - Active state uses B active voltage code.
// - Sleep state switches B to sleep voltage code.
// - B peak steps are code, or 4 x sleep code + 2 asleep.
// - Nonzero B spacing field spaces pulse starts at least 300 ns x (2 x field + 1).
module pfm_converter_top (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Chip control and sensing
  input  wire logic        sleep_state_i,
  input  wire logic [3:0]  vin_code_i,
  // Converter A power stage
  input  wire logic        conv_a_demand_i,
  input  wire logic        conv_a_peak_i,
  input  wire logic        conv_a_zero_i,
  output logic             conv_a_switch_on_o,
  output logic             conv_a_discharge_o,
  output logic             regc_pulse_o,
  output logic             regulator_op_o,
  output logic             regc_standalone_en_o,
  output logic             switched_rail_output_o,
  // Converter B power stage
  input  wire logic        conv_b_demand_i,
  input  wire logic        conv_b_peak_i,
  input  wire logic        conv_b_zero_i,
  output logic             conv_b_switch_on_o,
  output logic             conv_b_discharge_o,
  output logic      [7:0]  conv_b_target_code_o,
  output logic      [6:0]  conv_b_peak_steps_o
);
  logic [31:0] ctrl_a;
  logic [31:0] spacing;
  logic [31:0] ctrl_b;
  logic [31:0] peak_b;
  logic [31:0] count_a;
  logic [31:0] count_c;
  logic [31:0] status;
  logic        wr_stb;
  logic        rd_stb;
  logic [3:0]  on_cap_f;
  logic [3:0]  off_cap_f;
  logic [2:0]  mode_a;
  logic [3:0]  thr_f;
  logic [1:0]  mode_b;
  logic [3:0]  sp_a_f;
  logic [3:0]  sp_c_f;
  logic [3:0]  sp_b_f;
  logic [7:0]  act_v;
  logic [7:0]  slp_v;
  logic [5:0]  act_pk;
  logic [3:0]  slp_pk;
  logic        a_on;
  logic        b_on;
  logic        reg_op;
  logic        cnt_en;

  pfm_pulse_if pa ();
  pfm_pulse_if pb ();

  // ==========================================================
  // Helpers

  // Longest times round down to whole cycles
  // product form
  function automatic logic [pfm_pkg::TW-1:0] on_cycles(
    input logic [3:0] f);
    int ns;
    ns = pfm_pkg::ON_UNIT_NS * (1 + pfm_pkg::ON_MULT * int'(f));
    on_cycles = (f == '0) ? '0 : pfm_pkg::TW'(ns / pfm_pkg::CLK_PERIOD_NS);
  endfunction

  function automatic logic [pfm_pkg::TW-1:0] off_cycles(
    input logic [3:0] f);
    int ns;
    ns = pfm_pkg::OFF_UNIT_NS * int'(f);
    off_cycles = pfm_pkg::TW'(ns / pfm_pkg::CLK_PERIOD_NS);
  endfunction

  // Least times round up to whole cycles
  function automatic logic [pfm_pkg::TW-1:0] space_cycles(
    input logic [3:0] f);
    int ns;
    ns = pfm_pkg::SPACE_UNIT_NS * (pfm_pkg::SPACE_MULT * int'(f) + 1);
    space_cycles = (f == '0) ? '0 : pfm_pkg::TW'(
      (ns + pfm_pkg::CLK_PERIOD_NS - 1) / pfm_pkg::CLK_PERIOD_NS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = sel[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction

  // ==========================================================
  // Field extraction
  assign on_cap_f  = ctrl_a[pfm_pkg::CA_ON_LSB +: 4];
  assign off_cap_f = ctrl_a[pfm_pkg::CA_OFF_LSB +: 4];
  assign mode_a    = ctrl_a[pfm_pkg::CA_MODE_LSB +: 3];
  assign thr_f     = ctrl_a[pfm_pkg::CA_THR_LSB +: 4];
  assign cnt_en    = ctrl_a[pfm_pkg::CA_CC_BIT];
  assign sp_a_f    = spacing[pfm_pkg::SP_A_LSB +: 4];
  assign sp_c_f    = spacing[pfm_pkg::SP_C_LSB +: 4];
  assign sp_b_f    = spacing[pfm_pkg::SP_B_LSB +: 4];
  assign mode_b    = ctrl_b[pfm_pkg::CB_MODE_LSB +: 2];
  assign act_v     = ctrl_b[pfm_pkg::CB_ACT_LSB +: 8];
  assign slp_v     = ctrl_b[pfm_pkg::CB_SLP_LSB +: 8];
  assign act_pk    = peak_b[pfm_pkg::PB_ACT_LSB +: 6];
  assign slp_pk    = peak_b[pfm_pkg::PB_SLP_LSB +: 4];

  // ==========================================================
  // Wishbone slave, one wait state, every address acknowledged
  assign wr_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else       wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // Configuration registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_a  <= pfm_pkg::CTRL_A_RST;
      spacing <= pfm_pkg::SPACING_RST;
      ctrl_b  <= pfm_pkg::CTRL_B_RST;
      peak_b  <= pfm_pkg::PEAK_B_RST;
    end else if (wr_stb) begin
      case (wb_adr_i)
        pfm_pkg::REG_CTRL_A:  ctrl_a  <= merge(ctrl_a, wb_dat_i, wb_sel_i);
        pfm_pkg::REG_SPACING: spacing <= merge(spacing, wb_dat_i,
                                               wb_sel_i);
        pfm_pkg::REG_CTRL_B:  ctrl_b  <= merge(ctrl_b, wb_dat_i, wb_sel_i);
        pfm_pkg::REG_PEAK_B:  peak_b  <= merge(peak_b, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd_stb) begin
      case (wb_adr_i)
        pfm_pkg::REG_CTRL_A:  wb_dat_o <= ctrl_a;
        pfm_pkg::REG_SPACING: wb_dat_o <= spacing;
        pfm_pkg::REG_CTRL_B:  wb_dat_o <= ctrl_b;
        pfm_pkg::REG_PEAK_B:  wb_dat_o <= peak_b;
        pfm_pkg::REG_STATUS:  wb_dat_o <= status;
        pfm_pkg::REG_COUNT_A: wb_dat_o <= count_a;
        pfm_pkg::REG_COUNT_C: wb_dat_o <= count_c;
        default:              wb_dat_o <= '0;
      endcase
    end
  end

  always_comb begin
    status = '0;
    status[pfm_pkg::ST_REG_BIT]  = reg_op;
    status[pfm_pkg::ST_ACHG_BIT] = pa.charge;
    status[pfm_pkg::ST_ADIS_BIT] = pa.discharge;
    status[pfm_pkg::ST_BCHG_BIT] = pb.charge;
    status[pfm_pkg::ST_BDIS_BIT] = pb.discharge;
    status[pfm_pkg::ST_SLP_BIT]  = sleep_state_i;
  end

  // ==========================================================
  // Converter A and regulator C
  assign a_on = (mode_a != pfm_pkg::MODE_A_OFF);

  // Handover at or below threshold input level
  // threshold handover
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) reg_op <= 1'b0;
    else       reg_op <= (mode_a == pfm_pkg::MODE_A_WBR) &&
                         (vin_code_i <= thr_f);
  end

  // Regulator pulses finish at once: no inductor phases
  always_comb begin
    pa.req     = a_on && conv_a_demand_i;
    pa.peak    = reg_op || conv_a_peak_i;
    pa.zero    = reg_op || conv_a_zero_i;
    pa.on_cap  = reg_op ? '0 : on_cycles(on_cap_f);
    pa.off_cap = reg_op ? '0 : off_cycles(off_cap_f);
    pa.space   = reg_op ? space_cycles(sp_c_f) : space_cycles(sp_a_f);
  end

  pfm_pulse_engine u_eng_a (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pif       (pa.engine)
  );

  assign conv_a_switch_on_o = pa.charge && !reg_op;
  assign conv_a_discharge_o = pa.discharge && !reg_op;
  assign regc_pulse_o       = pa.start && reg_op;
  assign regulator_op_o     = reg_op;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) regc_standalone_en_o <= 1'b0;
    else       regc_standalone_en_o <= ctrl_a[pfm_pkg::CA_SA_BIT] &&
                                       (mode_a != pfm_pkg::MODE_A_WBR);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) switched_rail_output_o <= 1'b0;
    else       switched_rail_output_o <= ctrl_a[pfm_pkg::CA_SWR_BIT];
  end

  // Pulse counters; a pulse in the cycle of a clear still counts
  // count steering
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count_a <= '0;
    end else if (wr_stb && wb_adr_i == pfm_pkg::REG_COUNT_A) begin
      count_a <= {31'h0000_0000, cnt_en && pa.start && !reg_op};
    end else if (cnt_en && pa.start && !reg_op) begin
      count_a <= count_a + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count_c <= '0;
    end else if (wr_stb && wb_adr_i == pfm_pkg::REG_COUNT_C) begin
      count_c <= {31'h0000_0000, cnt_en && pa.start && reg_op};
    end else if (cnt_en && pa.start && reg_op) begin
      count_c <= count_c + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Converter B, buck only; other mode codes keep it still
  // buck codes
  assign b_on = (mode_b == pfm_pkg::MODE_B_BUCK) ||
                (mode_b == pfm_pkg::MODE_B_BREG);

  always_comb begin
    pb.req     = b_on && conv_b_demand_i;
    pb.peak    = conv_b_peak_i;
    pb.zero    = conv_b_zero_i;
    pb.on_cap  = '0;
    pb.off_cap = '0;
    pb.space   = space_cycles(sp_b_f);
  end

  pfm_pulse_engine u_eng_b (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pif       (pb.engine)
  );

  assign conv_b_switch_on_o = pb.charge;
  assign conv_b_discharge_o = pb.discharge;

  // Target and peak codes follow the energy state
  // state select
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      conv_b_target_code_o <= '0;
      conv_b_peak_steps_o  <= '0;
    end else if (sleep_state_i) begin
      conv_b_target_code_o <= slp_v;
      conv_b_peak_steps_o  <= 7'(pfm_pkg::PEAK_SLP_MULT * int'(slp_pk) +
                                 pfm_pkg::PEAK_SLP_OFS);
    end else begin
      conv_b_target_code_o <= act_v;
      conv_b_peak_steps_o  <= {1'b0, act_pk};
    end
  end
endmodule
`default_nettype wire

// ===== hdl/pfm_pkg.sv
`default_nettype none
package pfm_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL_A  = 8'h00;
  localparam logic [7:0] REG_SPACING = 8'h04;
  localparam logic [7:0] REG_CTRL_B  = 8'h08;
  localparam logic [7:0] REG_PEAK_B  = 8'h0C;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_COUNT_A = 8'h14;
  localparam logic [7:0] REG_COUNT_C = 8'h18;

  // ==========================================================
  // Field positions
  localparam int CA_ON_LSB    = 0;
  localparam int CA_OFF_LSB   = 4;
  localparam int CA_MODE_LSB  = 8;
  localparam int CA_SWR_BIT   = 11;
  localparam int CA_THR_LSB   = 12;
  localparam int CA_CC_BIT    = 16;
  localparam int CA_SA_BIT    = 17;
  localparam int SP_A_LSB     = 0;
  localparam int SP_C_LSB     = 4;
  localparam int SP_B_LSB     = 8;
  localparam int CB_MODE_LSB  = 0;
  localparam int CB_ACT_LSB   = 8;
  localparam int CB_SLP_LSB   = 16;
  localparam int PB_ACT_LSB   = 0;
  localparam int PB_SLP_LSB   = 8;
  localparam int ST_REG_BIT   = 0;
  localparam int ST_ACHG_BIT  = 1;
  localparam int ST_ADIS_BIT  = 2;
  localparam int ST_BCHG_BIT  = 3;
  localparam int ST_BDIS_BIT  = 4;
  localparam int ST_SLP_BIT   = 5;

  // ==========================================================
  // Reset values and field codes
  localparam logic [31:0] CTRL_A_RST  = 32'h0000_0000;
  localparam logic [31:0] SPACING_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_B_RST  = 32'h0000_0000;
  localparam logic [31:0] PEAK_B_RST  = 32'h0000_0000;
  localparam logic [2:0]  MODE_A_OFF  = 3'h0;
  localparam logic [2:0]  MODE_A_WBR  = 3'h3;
  localparam logic [1:0]  MODE_B_BUCK = 2'h1;
  localparam logic [1:0]  MODE_B_BREG = 2'h3;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int ON_UNIT_NS    = 70;
  localparam int ON_MULT       = 4;
  localparam int OFF_UNIT_NS   = 70;
  localparam int SPACE_UNIT_NS = 300;
  localparam int SPACE_MULT    = 2;
  localparam int PEAK_SLP_MULT = 4;
  localparam int PEAK_SLP_OFS  = 2;
  localparam int TW            = 16;

  typedef enum logic [1:0] {
    PFM_IDLE,
    PFM_CHARGE,
    PFM_DISCHARGE
  } pfm_state_t;
endpackage
`default_nettype wire

// ===== hdl/pfm_pulse_engine.sv
`default_nettype none
module pfm_pulse_engine (
  // Clock and reset
  input  wire logic  clk_sys_i,
  input  wire logic  rst_i,
  // Pulse channel
  pfm_pulse_if.engine pif
);
  pfm_pkg::pfm_state_t    state;
  pfm_pkg::pfm_state_t    next_state;
  logic [pfm_pkg::TW-1:0] tmr;
  logic [pfm_pkg::TW-1:0] gap;
  logic                   chg_end;
  logic                   dis_end;

  function automatic logic [pfm_pkg::TW-1:0] load_of(
    input logic [pfm_pkg::TW-1:0] c);
    load_of = (c == '0) ? '0 : c - 1'b1;
  endfunction

  // ==========================================================
  // Phase ends
  // cap or peak, whichever comes first
  assign chg_end = pif.peak || (pif.on_cap != '0 && tmr == '0);
  assign dis_end = pif.zero || (pif.off_cap != '0 && tmr == '0);
  assign pif.start     = (state == pfm_pkg::PFM_IDLE) && pif.req &&
                         (gap == '0);
  assign pif.charge    = (state == pfm_pkg::PFM_CHARGE);
  assign pif.discharge = (state == pfm_pkg::PFM_DISCHARGE);

  // Phase sequencing
  always_comb begin
    next_state = state;
    case (state)
      pfm_pkg::PFM_IDLE:
        if (pif.start) next_state = pfm_pkg::PFM_CHARGE;
      pfm_pkg::PFM_CHARGE:
        if (chg_end) next_state = pfm_pkg::PFM_DISCHARGE;
      pfm_pkg::PFM_DISCHARGE:
        if (dis_end) next_state = pfm_pkg::PFM_IDLE;
      default: next_state = pfm_pkg::PFM_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) state <= pfm_pkg::PFM_IDLE;
    else       state <= next_state;
  end

  // Phase timer; stays at zero while its cap is off
  // idle when disabled
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tmr <= '0;
    end else if (pif.start) begin
      tmr <= load_of(pif.on_cap);
    end else if (pif.charge && chg_end) begin
      tmr <= load_of(pif.off_cap);
    end else if (tmr != '0) begin
      tmr <= tmr - 1'b1;
    end
  end

  // Start-to-start spacing counter
  // minimum spacing
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      gap <= '0;
    end else if (pif.start) begin
      gap <= load_of(pif.space);
    end else if (gap != '0) begin
      gap <= gap - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/pfm_pulse_if.sv
`default_nettype none
interface pfm_pulse_if;
  // Configuration in cycles, zero means limit off
  logic [pfm_pkg::TW-1:0] on_cap;
  logic [pfm_pkg::TW-1:0] off_cap;
  logic [pfm_pkg::TW-1:0] space;
  // Sense and demand from the power stage
  logic                   req;
  logic                   peak;
  logic                   zero;
  // Pulse engine results
  logic                   start;
  logic                   charge;
  logic                   discharge;

  modport engine (
    input  on_cap, off_cap, space, req, peak, zero,
    output start, charge, discharge
  );
  modport ctrl (
    output on_cap, off_cap, space, req, peak, zero,
    input  start, charge, discharge
  );
endinterface
`default_nettype wire

// ===== test/pfm_converter_assertions.sv
`default_nettype none
module pfm_converter_assertions (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Bus and control
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_ack_o,
  input  wire logic       sleep_state_i,
  // Power stages
  input  wire logic       conv_a_peak_i,
  input  wire logic       conv_a_zero_i,
  input  wire logic       conv_a_switch_on_o,
  input  wire logic       conv_a_discharge_o,
  input  wire logic       conv_b_switch_on_o,
  input  wire logic       conv_b_discharge_o,
  input  wire logic       regc_pulse_o,
  input  wire logic       regulator_op_o,
  input  wire logic [6:0] conv_b_peak_steps_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Named steps
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_sleep_held;
    sleep_state_i [*3];
  endsequence
  sequence s_a_peak;
    conv_a_switch_on_o && conv_a_peak_i;
  endsequence
  a_ack_follows: assert property (s_wb_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_a_phases: assert property (
    !(conv_a_switch_on_o && conv_a_discharge_o))
    else $error("converter A charge and discharge together");
  a_b_phases: assert property (
    !(conv_b_switch_on_o && conv_b_discharge_o))
    else $error("converter B charge and discharge together");
  a_peak_ends: assert property (s_a_peak |=> !conv_a_switch_on_o)
    else $error("charge kept after peak");
  a_zero_ends: assert property (
    conv_a_discharge_o && conv_a_zero_i |=> !conv_a_discharge_o)
    else $error("discharge kept after zero detect");
  a_sleep_steps: assert property (
    s_sleep_held |-> conv_b_peak_steps_o[1:0] == 2'h2)
    else $error("sleep peak steps not four times code plus two");
  a_idle_gap: assert property (
    $rose(conv_a_switch_on_o) |-> !$past(conv_a_discharge_o))
    else $error("charge started without idle cycle");
  a_regc_steer: assert property (
    regc_pulse_o |-> regulator_op_o ##1 !regc_pulse_o)
    else $error("regulator pulse outside regulator operation");
endmodule
bind pfm_converter_top pfm_converter_assertions chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .sleep_state_i(sleep_state_i), .conv_a_peak_i(conv_a_peak_i),
  .conv_a_zero_i(conv_a_zero_i), .conv_a_switch_on_o(conv_a_switch_on_o),
  .conv_a_discharge_o(conv_a_discharge_o),
  .conv_b_switch_on_o(conv_b_switch_on_o),
  .conv_b_discharge_o(conv_b_discharge_o), .regc_pulse_o(regc_pulse_o),
  .regulator_op_o(regulator_op_o),
  .conv_b_peak_steps_o(conv_b_peak_steps_o));
`default_nettype wire

// ===== test/pfm_converter_pulse_timing_bench.sv
`default_nettype none
module pfm_converter_pulse_timing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, slp = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, dout;
  logic ack, dem_a = 0, dem_b = 0, hp_a = 0, hz_a = 0;
  logic [3:0] vin = 4'h0;
  logic pk_a, zr_a, on_a, dis_a, pk_b, zr_b, on_b, dis_b;
  logic rpulse, rop, sa_en, swr;
  logic [7:0] tgt;
  logic [6:0] steps;
  int n_fail = 0, n_tests = 0, len, n_rp = 0;
  always #2 clk = ~clk;
  pfm_converter_top uut (.clk_sys_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .sleep_state_i(slp),
    .vin_code_i(vin), .conv_a_demand_i(dem_a), .conv_a_peak_i(pk_a),
    .conv_a_zero_i(zr_a), .conv_a_switch_on_o(on_a),
    .conv_a_discharge_o(dis_a), .regc_pulse_o(rpulse),
    .regulator_op_o(rop), .regc_standalone_en_o(sa_en),
    .switched_rail_output_o(swr), .conv_b_demand_i(dem_b),
    .conv_b_peak_i(pk_b), .conv_b_zero_i(zr_b), .conv_b_switch_on_o(on_b),
    .conv_b_discharge_o(dis_b), .conv_b_target_code_o(tgt),
    .conv_b_peak_steps_o(steps));
  pfm_stage_model st_a (.clk_sys_i(clk), .switch_on_i(on_a),
    .discharge_i(dis_a), .hold_peak_i(hp_a), .hold_zero_i(hz_a),
    .peak_o(pk_a), .zero_o(zr_a));
  pfm_stage_model st_b (.clk_sys_i(clk), .switch_on_i(on_b),
    .discharge_i(dis_b), .hold_peak_i(1'b0), .hold_zero_i(1'b0),
    .peak_o(pk_b), .zero_o(zr_b));
  // Count regulator C pulses as the power stage sees them
  always @(posedge clk) if (rpulse === 1'b1) n_rp++;
  // ==========================================================
  // Bus cycles: hold the request until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dout;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb_cycle(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  function automatic logic sig(input int k);
    return (k == 0) ? on_a : (k == 1) ? dis_a : (k == 2) ? on_b : dis_b;
  endfunction
  // Cycles one phase stays high, or start to start when gap is set
  task automatic measure(input int k, input bit gap, output int n);
    int t;
    t = 0;
    n = 0;
    // A phase already under way may have been cut short by a write
    while (!gap && sig(k) === 1'b1 && t < 3000) begin
      @(posedge clk); t++;
    end
    while (sig(k) !== 1'b1 && t < 3000) begin @(posedge clk); t++; end
    while (sig(k) === 1'b1 && n < 2000) begin @(posedge clk); n++; end
    while (gap && sig(k) !== 1'b1 && n < 2000) begin
      @(posedge clk); n++;
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(pfm_pkg::REG_CTRL_A, pfm_pkg::CTRL_A_RST);
    rd_chk(pfm_pkg::REG_SPACING, pfm_pkg::SPACING_RST);
    rd_chk(pfm_pkg::REG_CTRL_B, pfm_pkg::CTRL_B_RST);
    rd_chk(pfm_pkg::REG_PEAK_B, pfm_pkg::PEAK_B_RST);
    rd_chk(8'h1C, 32'h0);
    // Capped charge, peak never reached: 70*5/4 cycles
    hp_a <= 1'b1; dem_a <= 1'b1;
    wb_cycle(1'b1, pfm_pkg::REG_CTRL_A, 32'h0000_0901);
    measure(0, 0, len);
    chk("on cap", 87, len);
    chk("switched rail", 1, swr);
    // Capped discharge, zero never seen: 70*2/4 cycles
    hp_a <= 1'b0; hz_a <= 1'b1;
    wb_cycle(1'b1, pfm_pkg::REG_CTRL_A, 32'h0000_0120);
    measure(1, 0, len);
    chk("off cap", 35, len);
    wb_cycle(1'b1, pfm_pkg::REG_CTRL_A, 32'h0000_0100);
    measure(1, 0, len);
    chk("uncapped discharge", 1, len >= 1000);
    dem_a <= 1'b0; hz_a <= 1'b0;
    chk("switched rail off", 0, swr);
    // A spacing only: regulator pulses pass, switching ones are thinned
    wb_cycle(1'b1, pfm_pkg::REG_SPACING, 32'h0000_0001);
    // Parallel mode, regulator operation below the threshold
    wb_cycle(1'b1, pfm_pkg::REG_CTRL_A, 32'h0003_F300);
    repeat (4) @(posedge clk);
    chk("regulator op", 1, rop);
    chk("standalone off", 0, sa_en);
    repeat (5) begin
      dem_a <= 1'b1; @(posedge clk); dem_a <= 1'b0; repeat (6) @(posedge clk);
    end
    vin <= 4'h5;
    wb_cycle(1'b1, pfm_pkg::REG_CTRL_A, 32'h0001_0300);
    repeat (4) @(posedge clk);
    chk("switching op", 0, rop);
    repeat (3) begin
      dem_a <= 1'b1; @(posedge clk); dem_a <= 1'b0; repeat (30) @(posedge clk);
    end
    rd_chk(pfm_pkg::REG_COUNT_C, 32'h5);
    chk("regc pulses", 5, n_rp);
    rd_chk(pfm_pkg::REG_COUNT_A, 32'h1);
    wb_cycle(1'b1, pfm_pkg::REG_CTRL_A, 32'h0002_0100);
    repeat (3) @(posedge clk);
    chk("standalone on", 1, sa_en);
    // Converter B codes in active and sleep states
    wb_cycle(1'b1, pfm_pkg::REG_CTRL_B, 32'h0015_2A01);
    wb_cycle(1'b1, pfm_pkg::REG_PEAK_B, 32'h0000_0533);
    rd_chk(pfm_pkg::REG_CTRL_B, 32'h0015_2A01);
    chk("active target", 8'h2A, tgt);
    chk("active steps", 7'h33, steps);
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    chk("sleep target", 8'h15, tgt);
    chk("sleep steps", 7'h16, steps);
    rd_chk(pfm_pkg::REG_STATUS, 32'h0000_0020);
    slp <= 1'b0;
    // Converter B start spacing: ceil(300*3/4) cycles
    wb_cycle(1'b1, pfm_pkg::REG_SPACING, 32'h0000_0100);
    dem_b <= 1'b1;
    measure(2, 1, len);
    measure(2, 1, len);
    chk("spacing min", 1, len >= 225 && len <= 228);
    wb_cycle(1'b1, pfm_pkg::REG_SPACING, 32'h0);
    measure(2, 1, len);
    measure(2, 1, len);
    chk("spacing off", 1, len < 40);
    measure(3, 0, len);
    chk("B discharge", 1, len > 0 && len < 40);
    wb_cycle(1'b1, pfm_pkg::REG_CTRL_B, 32'h0000_0002);
    repeat (40) @(posedge clk);
    chk("mode 2 refused", 0, on_b);
    dem_b <= 1'b0;
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== test/pfm_stage_model.sv
`default_nettype none
module pfm_stage_model #(
  parameter int DLY = 3
) (
  // Clock
  input  wire logic clk_sys_i,
  // Phase drive from the block
  input  wire logic switch_on_i,
  input  wire logic discharge_i,
  // Faults commanded by the bench
  input  wire logic hold_peak_i,
  input  wire logic hold_zero_i,
  // Comparator outputs
  output logic      peak_o,
  output logic      zero_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  logic [1:0] ph_q;
  int         cnt;
  logic       settled;
  // ==========================================================
  // Phase timer restarts whenever the drive changes phase
  assign ph = {switch_on_i, discharge_i};
  always_ff @(posedge clk_sys_i) begin
    ph_q <= ph;
    cnt  <= (ph !== ph_q) ? 0 : cnt + 1;
  end
  // The timer lags a phase change by one edge, so the first cycle of a
  // new phase must read as age zero, not as the age of the old phase
  assign settled = (ph === ph_q) && (cnt >= DLY);
  // held peak comparator
  // A held comparator models a weak source that never reaches peak,
  // so only the on-time cap can end the charge phase
  // held zero detect
  always_comb begin
    peak_o = switch_on_i && settled && !hold_peak_i;
    zero_o = discharge_i && settled && !hold_zero_i;
  end
endmodule
`default_nettype wire
